// File: verilog/eeprom_port_pkg.sv
package eeprom_port_pkg;

  // clocking of the card and the serial memory
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SK_HALF_NS = 160;
  // least time, so round up to whole cycles
  localparam int unsigned SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register map, printed index times four gives the byte address
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PORT_INDEX = 8'h0A;
  localparam logic [ADDR_W-1:0] PORT_ADDR = {PORT_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h40;

  // port byte layout
  localparam int unsigned SER_DATA_BIT = 7;
  localparam int unsigned STROBE_BIT = 0;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // status register layout
  localparam int unsigned ST_WREN_BIT = 0;
  localparam int unsigned ST_SELECT_BIT = 1;
  localparam int unsigned ST_BLOCK_BIT = 2;
  localparam int unsigned ST_OPEN_BIT = 3;
  localparam int unsigned ST_BITS_LSB = 8;
  localparam int unsigned ST_READS_LSB = 16;

  // serial instruction layout
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
  localparam logic [CNT_W-1:0] OP_HI_POS = 5'h00;
  localparam logic [CNT_W-1:0] OP_LO_POS = 5'h01;
  localparam logic [CNT_W-1:0] EXT_HI_POS = 5'h02;
  localparam logic [CNT_W-1:0] EXT_LO_POS = 5'h03;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  // the enable sequence carries 1 then 0 in the two bits after the opcode
  localparam logic [1:0] EXT_ERASE_ALL = 2'h3;
  localparam logic [1:0] EXT_ENABLE = 2'h2;

  typedef enum {AP_IDLE, AP_WAIT, AP_DONE} apb_state_t;
  typedef enum {PH_IDLE, PH_LOW, PH_HIGH} strobe_phase_t;

  // exact match of a bus address against a register, all bits compared
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction

endpackage

// File: verilog/bit_sync2.sv
`timescale 1ns/1ns
module bit_sync2
  import eeprom_port_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // only the second stage is visible to the rest of the block
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule

// File: verilog/serial_strobe_gen.sv
`timescale 1ns/1ns
module serial_strobe_gen
  import eeprom_port_pkg::*;
#(
  parameter int unsigned HALF_CYC = SK_HALF_CYC
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic sk_o,
  output logic done_o
);

  localparam int unsigned DIV_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);

  strobe_phase_t phase;
  strobe_phase_t next_phase;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] next_div;
  logic tick;
  logic next_sk;
  logic next_done;

  // divider restarts with each strobe so every half period is whole
  assign tick = (div == DIV_LAST);

  // low half gives data setup, high half is the clocking edge
  always_comb begin
    next_phase = phase;
    next_div = (phase == PH_IDLE || tick) ? '0 : div + DIV_W'(1);
    next_sk = sk_o;
    next_done = 1'b0;
    unique case (phase)
      PH_IDLE: begin
        if (start_i) begin
          next_phase = PH_LOW;
        end
      end
      PH_LOW: begin
        if (tick) begin
          next_phase = PH_HIGH;
          next_sk = 1'b1;
        end
      end
      PH_HIGH: begin
        if (tick) begin
          next_phase = PH_IDLE;
          next_sk = 1'b0;
          next_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= PH_IDLE;
      div <= '0;
      sk_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      phase <= next_phase;
      div <= next_div;
      sk_o <= next_sk;
      done_o <= next_done;
    end
  end

endmodule

// File: verilog/serial_eeprom_bitbang_port.sv
// Operation
// - stored words protected until enable sequence seen
// - write frame: start, opcode 01, address, data
// - serial bit in bit 7, bit 0 held high
// - read: nine writes, sixteen reads, one end
// - each read returns next data bit, MSB first
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module serial_eeprom_bitbang_port
  import eeprom_port_pkg::*;
#(
  parameter int unsigned HALF_CYC = SK_HALF_CYC
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic eeprom_cs_o,
  output logic eeprom_sk_o,
  output logic eeprom_di_o,
  input wire logic eeprom_do_i
);

  apb_state_t state;
  apb_state_t next_state;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  // pin state
  logic next_cs;
  logic next_di;
  logic start_strobe;
  logic strobe_done;
  logic do_sync;
  logic sk_int;

  // frame tracking state
  logic frame_open;
  logic next_frame_open;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic [CNT_W-1:0] read_cnt;
  logic [CNT_W-1:0] next_read_cnt;
  logic [1:0] opcode;
  logic [1:0] next_opcode;
  logic ext_hi;
  logic next_ext_hi;
  logic wr_enabled;
  logic next_wr_enabled;
  logic blocked;
  logic next_blocked;

  // bus decode
  logic access;
  logic port_hit;
  logic status_hit;
  logic ser_bit;
  logic strobe_bit;
  logic [31:0] status_word;

  assign access = psel_i && penable_i;
  assign port_hit = addr_hit(paddr_i, PORT_ADDR);
  assign status_hit = addr_hit(paddr_i, STATUS_ADDR);
  assign ser_bit = pwdata_i[SER_DATA_BIT];
  assign strobe_bit = pwdata_i[STROBE_BIT];

  // memory output arrives from a pin, so it is synchronised first
  bit_sync2 u_do_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(eeprom_do_i),
    .sync_o(do_sync)
  );

  // one full serial clock per strobed write or port read
  serial_strobe_gen #(
    .HALF_CYC(HALF_CYC)
  ) u_strobe (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(start_strobe),
    .sk_o(sk_int),
    .done_o(strobe_done)
  );

  assign eeprom_sk_o = sk_int;

  // status word shows the tracker so software can check protection
  always_comb begin
    status_word = '0;
    status_word[ST_WREN_BIT] = wr_enabled;
    status_word[ST_SELECT_BIT] = eeprom_cs_o;
    status_word[ST_BLOCK_BIT] = blocked;
    status_word[ST_OPEN_BIT] = frame_open;
    status_word[ST_BITS_LSB +: CNT_W] = bit_cnt;
    status_word[ST_READS_LSB +: CNT_W] = read_cnt;
  end

  // bus handshake: strobed port writes and port reads wait for the serial clock,
  // every other access answers after one wait cycle
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata_o;
    start_strobe = 1'b0;
    unique case (state)
      AP_IDLE: begin
        if (access) begin
          if (port_hit && pwrite_i) begin
            if (strobe_bit) begin
              start_strobe = 1'b1;
              next_state = AP_WAIT;
            end else begin
              next_pready = 1'b1;
              next_state = AP_DONE;
            end
          end else if (port_hit) begin
            // sample before clocking so the bit already on the pin is returned
            next_prdata = '0;
            next_prdata[SER_DATA_BIT] = do_sync;
            start_strobe = 1'b1;
            next_state = AP_WAIT;
          end else if (status_hit) begin
            // writes to the status word are accepted and ignored
            next_prdata = pwrite_i ? prdata_o : status_word;
            next_pready = 1'b1;
            next_state = AP_DONE;
          end else begin
            next_prdata = '0;
            next_pready = 1'b1;
            next_pslverr = 1'b1;
            next_state = AP_DONE;
          end
        end
      end
      AP_WAIT: begin
        if (strobe_done) begin
          next_pready = 1'b1;
          next_state = AP_DONE;
        end
      end
      AP_DONE: begin
        // the master releases at this edge, so no stale access is seen
        next_state = AP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= AP_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      state <= next_state;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o <= next_prdata;
    end
  end

  // frame tracker: follows the instruction bits the host shifts out
  // and keeps the memory deselected for altering frames until enabled
  always_comb begin
    next_frame_open = frame_open;
    next_bit_cnt = bit_cnt;
    next_read_cnt = read_cnt;
    next_opcode = opcode;
    next_ext_hi = ext_hi;
    next_wr_enabled = wr_enabled;
    next_blocked = blocked;
    next_cs = eeprom_cs_o;
    next_di = eeprom_di_o;
    if (state == AP_IDLE && access && port_hit && pwrite_i) begin
      if (!strobe_bit) begin
        // a cleared strobe ends any frame and deselects
        next_frame_open = 1'b0;
        next_bit_cnt = '0;
        next_read_cnt = '0;
        next_blocked = 1'b0;
        next_cs = 1'b0;
        next_di = 1'b0;
      end else begin
        next_di = ser_bit;
        if (!frame_open) begin
          // leading zeros before the start bit are idle clocks
          next_frame_open = ser_bit;
          next_bit_cnt = '0;
        end else begin
          if (bit_cnt != CNT_MAX) begin
            next_bit_cnt = bit_cnt + CNT_W'(1);
          end
          if (bit_cnt == OP_HI_POS) begin
            next_opcode = {ser_bit, 1'b0};
          end
          if (bit_cnt == OP_LO_POS) begin
            next_opcode = {opcode[1], ser_bit};
            if (({opcode[1], ser_bit} == OP_WRITE || {opcode[1], ser_bit} == OP_ERASE)
                && !wr_enabled) begin
              next_blocked = 1'b1;
            end
          end
          if (bit_cnt == EXT_HI_POS) begin
            next_ext_hi = ser_bit;
          end
          if (bit_cnt == EXT_LO_POS && opcode == OP_EXT) begin
            unique case ({ext_hi, ser_bit})
              EXT_ENABLE: next_wr_enabled = 1'b1;
              EXT_DISABLE: next_wr_enabled = 1'b0;
              EXT_WRITE_ALL, EXT_ERASE_ALL: begin
                if (!wr_enabled) begin
                  next_blocked = 1'b1;
                end
              end
            endcase
          end
        end
        // dropping select mid-instruction makes the memory discard it
        next_cs = !next_blocked;
      end
    end else if (state == AP_IDLE && access && port_hit && !pwrite_i) begin
      if (read_cnt != CNT_MAX) begin
        next_read_cnt = read_cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_open <= 1'b0;
      bit_cnt <= '0;
      read_cnt <= '0;
      opcode <= OP_EXT;
      ext_hi <= 1'b0;
      wr_enabled <= 1'b0;
      blocked <= 1'b0;
      eeprom_cs_o <= PORT_RESET[STROBE_BIT];
      eeprom_di_o <= PORT_RESET[SER_DATA_BIT];
    end else begin
      frame_open <= next_frame_open;
      bit_cnt <= next_bit_cnt;
      read_cnt <= next_read_cnt;
      opcode <= next_opcode;
      ext_hi <= next_ext_hi;
      wr_enabled <= next_wr_enabled;
      blocked <= next_blocked;
      eeprom_cs_o <= next_cs;
      eeprom_di_o <= next_di;
    end
  end

endmodule

// File: tb/eeprom_port_props.sv
`timescale 1ns/1ns
module eeprom_port_props
  import eeprom_port_pkg::*;
#(
  parameter int unsigned HALF_CYC = SK_HALF_CYC
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic eeprom_cs_o,
  input wire logic eeprom_sk_o,
  input wire logic eeprom_di_o
);
  logic hit;
  // access phase aimed at the port; penable drops between transfers
  assign hit = psel_i && penable_i && paddr_i == PORT_ADDR;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_sk_needs_cs: assert property ($changed(eeprom_cs_o) |-> !eeprom_sk_o)
    else $error("select moved while serial clock high");
  chk_di_held: assert property (eeprom_sk_o && $past(eeprom_sk_o) |->
    $stable({eeprom_cs_o, eeprom_di_o})) else $error("data moved while clock high");
  chk_sk_width: assert property ($rose(eeprom_sk_o) |->
    eeprom_sk_o[*4] ##1 !eeprom_sk_o) else $error("serial clock width wrong");
  chk_write_clocks: assert property ($rose(hit) && pwrite_i && pwdata_i[0] |->
    ##[1:12] $rose(eeprom_sk_o)) else $error("strobed write gave no clock");
  chk_clear_desel: assert property ($rose(hit) && pwrite_i && !pwdata_i[0] |->
    ##[1:3] !eeprom_cs_o) else $error("clear write kept memory selected");
  chk_di_value: assert property ($rose(eeprom_sk_o) && pwrite_i |->
    eeprom_di_o == pwdata_i[7]) else $error("serial data not bit 7");
  chk_read_clocks: assert property ($rose(hit) && !pwrite_i |->
    ##[1:12] $rose(eeprom_sk_o)) else $error("port read gave no clock");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held two cycles");
  chk_err_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error without ready or with data");
endmodule

bind serial_eeprom_bitbang_port eeprom_port_props #(.HALF_CYC(HALF_CYC)) i_eeprom_port_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .eeprom_cs_o(eeprom_cs_o),
  .eeprom_sk_o(eeprom_sk_o), .eeprom_di_o(eeprom_di_o));

// File: tb/eeprom_model.sv
`timescale 1ns/1ns
module eeprom_model (
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic di_i,
  output logic do_o
);
  logic [15:0] mem [64];
  logic [24:0] sh;
  logic [15:0] q;
  logic wen;
  logic rd;
  int n;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    sh = 25'h0;
    q = 16'h0;
    wen = 1'b0;
    rd = 1'b0;
    n = 0;
  end
  // shift in on the rising clock; zeros before the start bit are ignored
  always @(posedge sk_i) begin
    if (cs_i && rd) begin
      q = {q[14:0], 1'b0};
    end else if (cs_i && (n > 0 || di_i)) begin
      sh = {sh[23:0], di_i};
      n = n + 1;
      if (n == 5 && sh[3:2] == 2'b00) wen = sh[1];
      if (n == 9 && sh[7:6] == 2'b10) begin
        rd = 1'b1;
        q = mem[sh[5:0]];
      end
      if (n == 25 && sh[23:22] == 2'b01 && wen) mem[sh[21:16]] = sh[15:0];
    end
  end
  // deselect aborts any instruction in flight
  always @(negedge cs_i) begin
    n = 0;
    rd = 1'b0;
  end
  // released line shows the inverse, never a stale copy
  assign do_o = rd ? q[15] : ~q[15];
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import eeprom_port_pkg::*;
  logic clock_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, errq, pdo;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rdq;
  logic prdy, perr, cs, sk, di;
  logic [15:0] w;
  int err_count = 0, compares = 0, cyc = 0;
  always #20 clock_i = ~clock_i;
  serial_eeprom_bitbang_port i_serial_eeprom_bitbang_port (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .eeprom_cs_o(cs), .eeprom_sk_o(sk), .eeprom_di_o(di),
    .eeprom_do_i(pdo));
  eeprom_model i_eeprom_model (.cs_i(cs), .sk_i(sk), .di_i(di), .do_o(pdo));
  task automatic chk_bit(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    int t;
    @(posedge clock_i);
    psel <= 1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1;
    t = 0;
    do begin
      @(posedge clock_i);
      t++;
    end while (prdy !== 1'b1 && t < 100);
    rdq = prd;
    errq = perr;
    psel <= 0;
    pen <= 0;
    if (t >= 100) err_count++;
  endtask
  task automatic wb(logic [7:0] b);
    xfer(1, PORT_ADDR, {24'h0, b});
  endtask
  task automatic sbit(logic b);
    wb({b, 6'h00, 1'b1});
  endtask
  task automatic send(logic [7:0] s [9]);
    foreach (s[i]) wb(s[i]);
  endtask
  task automatic wr_word(logic [5:0] a, logic [15:0] d);
    sbit(1);
    sbit(0);
    sbit(1);
    for (int i = 5; i >= 0; i--) sbit(a[i]);
    for (int i = 15; i >= 0; i--) sbit(d[i]);
    wb(8'h00);
  endtask
  task automatic rd_word(logic [5:0] a);
    sbit(1);
    sbit(1);
    sbit(0);
    for (int i = 5; i >= 0; i--) sbit(a[i]);
    for (int i = 15; i >= 0; i--) begin
      xfer(0, PORT_ADDR, 32'h0);
      w[i] = rdq[7];
    end
    wb(8'h00);
  endtask
  // an altering opcode must drop the select while writes are locked
  task automatic try_locked();
    sbit(1);
    sbit(0);
    sbit(1);
    @(negedge clock_i);
    chk_bit("locked select", 1'b0, cs);
    wb(8'h00);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cuts a hang short; about 2300 cycles are expected
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1;
    @(negedge clock_i);
    chk_bit("idle select", 1'b0, cs);
    $display("test reset done");
    try_locked();
    rd_word(6'h05);
    chk_word("unwritten word", 32'hFFFF, {16'h0, w});
    $display("test locked done");
    send('{8'h81, 8'h01, 8'h01, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00});
    wr_word(6'h05, 16'hAA55);
    wr_word(6'h06, 16'h0001);
    send('{8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00});
    rd_word(6'h05);
    chk_word("word 5", 32'hAA55, {16'h0, w});
    rd_word(6'h06);
    chk_word("word 6", 32'h0001, {16'h0, w});
    $display("test program done");
    try_locked();
    rd_word(6'h05);
    chk_word("kept word", 32'hAA55, {16'h0, w});
    $display("test relock done");
    xfer(0, 8'h3C, 32'h0);
    chk_bit("unmapped error", 1'b1, errq);
    chk_word("unmapped data", 32'h0, rdq);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
